// ===== logic/eepw_top.v
// Serial EEPROM slave: page write, write cycle, write protect and reads
// Overview of operation
// RQ1: Page write buffers up to 32 bytes
// RQ2: Offset wraps inside the latched page
// RQ3: STOP commits buffer in one write cycle
// RQ4: No acknowledge while write cycle runs
// RQ5: Master may repeat refused request (polling)
// RQ6: High write-protect blocks all writes
// RQ7: Write-protect sampled before first data byte
// RQ8: Protected data byte unacknowledged, request discarded
// RQ9: Array starts erased, all bytes FFh
// RQ10: Read address acknowledged, current byte shifted
// RQ11: Master ends read with no-ack, STOP
// RQ12: Read end returns to idle
// RQ13: Two address bytes load internal address
// RQ14: Repeated START read returns addressed byte
// RQ15: Master acknowledge continues with next byte
// RQ16: Read address wraps at array end
// RQ17: Respond only to 1010 plus straps
// RQ18: Master sends two address bytes first
// RQ19: STOP launches write; line stays released
// RQ20: Sample on rising, drive after falling
// RQ21: Twelve-bit address, upper bits ignored
`timescale 1ns/10ps
`default_nettype none
`include "eepw_map.vh"
module eepw_top #(
  parameter integer WRITE_CYCLES = `EEPW_TWR_US * `EEPW_CLK_MHZ,
  parameter PAGE_BYTES = `EEPW_PAGE_BYTES
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Serial bus pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  // Straps and write protect
  input wire chip_select_strap_0,
  input wire chip_select_strap_1,
  input wire chip_select_strap_2,
  input wire write_protect,
  // Status
  output reg write_busy
);
  localparam ST_IDLE = 3'h0;
  localparam ST_RX = 3'h1;
  localparam ST_RXACK = 3'h2;
  localparam ST_TX = 3'h3;
  localparam ST_TXACK = 3'h4;
  localparam [`EEPW_TIMER_W-1:0] TWR_LAST = WRITE_CYCLES[`EEPW_TIMER_W-1:0] - 1'b1;
  localparam [5:0] COMMIT_END = PAGE_BYTES[5:0];

  // ==========================================================
  // Input synchronisers
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  reg scl_q_reg;
  reg sda_q_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 6'h03;
      sync2_reg <= 6'h03;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      sync1_reg <= {write_protect, chip_select_strap_2, chip_select_strap_1,
                    chip_select_strap_0, sda_in, scl_in};
      sync2_reg <= sync1_reg;
      scl_q_reg <= sync2_reg[0];
      sda_q_reg <= sync2_reg[1];
    end
  end
  wire scl_s = sync2_reg[0];
  wire sda_s = sync2_reg[1];
  wire [2:0] strap_s = sync2_reg[4:2];
  wire wp_s = sync2_reg[5];
  wire scl_rise = scl_s & ~scl_q_reg;
  wire scl_fall = ~scl_s & scl_q_reg;
  wire bus_start = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  wire bus_stop = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

  // ==========================================================
  // Protocol state
  reg [2:0] state_reg;
  reg [1:0] phase_reg;
  reg [3:0] cnt_reg;
  reg [7:0] sh_reg;
  reg [7:0] tx_reg;
  reg [7:0] ahi_reg;
  reg [`EEPW_ADDR_W-1:0] addr_reg;
  reg [`EEPW_PAGE_W-1:0] page_reg;
  reg [`EEPW_OFF_W-1:0] off_reg;
  reg rw_reg;
  reg wp_latched_reg;
  reg [PAGE_BYTES-1:0] valid_reg;
  reg wr_pend_reg;
  reg [`EEPW_TIMER_W-1:0] timer_reg;
  reg [5:0] commit_reg;
  reg buf_we;
  reg [7:0] buf_data [0:PAGE_BYTES-1];
  wire [7:0] mem_rdata;
  wire [7:0] rx_byte = {sh_reg[6:0], sda_s};
  wire [7:0] last_byte = sh_reg;
  wire dev_match = (last_byte[7:4] == `EEPW_DEV_TYPE) && (last_byte[3:1] == strap_s); // RQ17
  wire commit_we = write_busy && (commit_reg != COMMIT_END) && valid_reg[commit_reg[4:0]];

  eepw_mem #(
    .AW(`EEPW_ADDR_W),
    .DW(`EEPW_DATA_W)
  ) u_mem (
    .clk(clk),
    .rst(rst),
    .we(commit_we),
    .waddr({page_reg, commit_reg[4:0]}),
    .wdata(buf_data[commit_reg[4:0]]),
    .raddr(addr_reg),
    .rdata(mem_rdata)
  );

  // Page buffer data needs no reset; valid bits guard it
  always @(posedge clk) begin
    if (buf_we) begin
      buf_data[off_reg] <= last_byte; // RQ1
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      phase_reg <= `EEPW_PH_DEV;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      ahi_reg <= 8'h00;
      addr_reg <= {`EEPW_ADDR_W{1'b0}};
      page_reg <= {`EEPW_PAGE_W{1'b0}};
      off_reg <= {`EEPW_OFF_W{1'b0}};
      rw_reg <= 1'b0;
      wp_latched_reg <= 1'b0;
      valid_reg <= {PAGE_BYTES{1'b0}};
      wr_pend_reg <= 1'b0;
      timer_reg <= {`EEPW_TIMER_W{1'b0}};
      commit_reg <= 6'h00;
      write_busy <= 1'b0;
      buf_we <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      buf_we <= 1'b0;
      // Internal write cycle; page is copied one byte per clock
      if (write_busy) begin
        if (commit_reg != COMMIT_END) begin
          commit_reg <= commit_reg + 6'h01; // RQ3
        end
        if (timer_reg == {`EEPW_TIMER_W{1'b0}}) begin
          write_busy <= 1'b0;
          valid_reg <= {PAGE_BYTES{1'b0}};
        end else begin
          timer_reg <= timer_reg - 1'b1;
        end
      end
      if (bus_stop) begin
        state_reg <= ST_IDLE; // RQ12
        sda_oe_n <= 1'b1; // RQ19
        if (wr_pend_reg && !write_busy) begin
          write_busy <= 1'b1; // RQ19
          timer_reg <= TWR_LAST;
          commit_reg <= 6'h00;
          wr_pend_reg <= 1'b0;
        end
      end else if (bus_start) begin
        // A restart without STOP abandons any loaded page
        state_reg <= ST_RX;
        phase_reg <= `EEPW_PH_DEV;
        cnt_reg <= 4'h0;
        sda_oe_n <= 1'b1;
        if (!write_busy) begin
          wr_pend_reg <= 1'b0;
          valid_reg <= {PAGE_BYTES{1'b0}};
        end
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          ST_RX: begin
            if (scl_rise) begin
              sh_reg <= rx_byte; // RQ20
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == `EEPW_BYTE_BITS) begin
              case (phase_reg)
                `EEPW_PH_DEV: begin
                  if (dev_match && !write_busy) begin // RQ4
                    rw_reg <= last_byte[0];
                    sda_oe_n <= 1'b0;
                    state_reg <= ST_RXACK;
                  end else begin
                    state_reg <= ST_IDLE; // RQ5
                  end
                end
                `EEPW_PH_AHI: begin
                  ahi_reg <= last_byte; // RQ13
                  sda_oe_n <= 1'b0;
                  state_reg <= ST_RXACK;
                end
                `EEPW_PH_ALO: begin
                  addr_reg <= {ahi_reg[3:0], last_byte}; // RQ21
                  page_reg <= {ahi_reg[3:0], last_byte[7:5]}; // RQ2
                  off_reg <= last_byte[4:0];
                  sda_oe_n <= 1'b0;
                  state_reg <= ST_RXACK;
                end
                default: begin
                  if (wp_latched_reg) begin
                    // Whole request dropped, nothing reaches the array
                    wr_pend_reg <= 1'b0; // RQ8
                    valid_reg <= {PAGE_BYTES{1'b0}}; // RQ6
                    state_reg <= ST_IDLE;
                  end else begin
                    buf_we <= 1'b1;
                    valid_reg[off_reg] <= 1'b1; // RQ1
                    wr_pend_reg <= 1'b1;
                    sda_oe_n <= 1'b0;
                    state_reg <= ST_RXACK;
                  end
                end
              endcase
            end
          end
          ST_RXACK: begin
            if (scl_fall) begin
              cnt_reg <= 4'h0;
              if (buf_we == 1'b0 && phase_reg == `EEPW_PH_DAT) begin
                off_reg <= off_reg + 1'b1; // RQ2
                addr_reg <= {page_reg, off_reg + 1'b1};
              end
              case (phase_reg)
                `EEPW_PH_DEV: begin
                  if (rw_reg) begin
                    tx_reg <= mem_rdata; // RQ10
                    addr_reg <= addr_reg + 1'b1; // RQ16
                    sda_oe_n <= mem_rdata[7];
                    cnt_reg <= 4'h1;
                    state_reg <= ST_TX; // RQ14
                  end else begin
                    sda_oe_n <= 1'b1;
                    phase_reg <= `EEPW_PH_AHI; // RQ18
                    state_reg <= ST_RX;
                  end
                end
                `EEPW_PH_AHI: begin
                  sda_oe_n <= 1'b1;
                  phase_reg <= `EEPW_PH_ALO;
                  state_reg <= ST_RX;
                end
                `EEPW_PH_ALO: begin
                  wp_latched_reg <= wp_s; // RQ7
                  sda_oe_n <= 1'b1;
                  phase_reg <= `EEPW_PH_DAT;
                  state_reg <= ST_RX;
                end
                default: begin
                  sda_oe_n <= 1'b1;
                  state_reg <= ST_RX;
                end
              endcase
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (cnt_reg == `EEPW_BYTE_BITS) begin
                sda_oe_n <= 1'b1;
                state_reg <= ST_TXACK;
              end else begin
                sda_oe_n <= tx_reg[6]; // RQ20
                tx_reg <= {tx_reg[6:0], 1'b0};
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
          ST_TXACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                state_reg <= ST_IDLE; // RQ11
              end
            end else if (scl_fall) begin
              tx_reg <= mem_rdata; // RQ15
              addr_reg <= addr_reg + 1'b1; // RQ16
              sda_oe_n <= mem_rdata[7];
              cnt_reg <= 4'h1;
              state_reg <= ST_TX;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/eepw_map.vh
// Constants for the serial EEPROM slave access logic
`ifndef EEPW_MAP_VH
`define EEPW_MAP_VH
// Device type code in the upper four slave address bits
`define EEPW_DEV_TYPE 4'hA
// Erased byte value
`define EEPW_ERASED 8'hFF
// Array geometry
`define EEPW_ADDR_W 12
`define EEPW_DATA_W 8
`define EEPW_PAGE_BYTES 32
`define EEPW_OFF_W 5
`define EEPW_PAGE_W 7
// Bits per byte on the bus
`define EEPW_BYTE_BITS 4'h8
// Internal write time in microseconds and core clock rate in MHz
`define EEPW_TWR_US 4000
`define EEPW_CLK_MHZ 100
`define EEPW_TIMER_W 19
// Phases of a received byte
`define EEPW_PH_DEV 2'h0
`define EEPW_PH_AHI 2'h1
`define EEPW_PH_ALO 2'h2
`define EEPW_PH_DAT 2'h3
`endif

// ===== logic/eepw_mem.v
// Flip-flop storage array of the EEPROM, erased at reset
`timescale 1ns/10ps
`default_nettype none
`include "eepw_map.vh"
module eepw_mem #(
  parameter AW = `EEPW_ADDR_W,
  parameter DW = `EEPW_DATA_W
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  // Read port, combinational
  input wire [AW-1:0] raddr,
  output wire [DW-1:0] rdata
);
  reg [DW-1:0] mem_reg [0:(1<<AW)-1];
  integer i;

  // ==========================================================
  // Storage
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < (1<<AW); i = i + 1) begin
        mem_reg[i] <= `EEPW_ERASED; // RQ9
      end
    end else if (we) begin
      mem_reg[waddr] <= wdata;
    end
  end

  assign rdata = mem_reg[raddr];
endmodule
`default_nettype wire

// ===== verification/eepw_checker.sv
// Pin-level assertions for the serial EEPROM slave
`timescale 1ns/10ps
`default_nettype none
module eepw_checker #(
  parameter integer WRITE_CYCLES = 400
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus pins, protect and status
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic write_protect,
  input wire logic write_busy
);
  logic [19:0] busy_cnt_reg;
  logic [7:0] wp_cnt_reg;
  // Protect count saturates; a protected request holds it far beyond 150 cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt_reg <= 20'h00000;
      wp_cnt_reg <= 8'h00;
    end else begin
      busy_cnt_reg <= write_busy ? busy_cnt_reg + 20'h00001 : 20'h00000;
      wp_cnt_reg <= write_protect ? wp_cnt_reg + {7'h00, ~&wp_cnt_reg} : 8'h00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_bus_idle;
    scl_in && sda_in;
  endsequence
  sequence s_ack_held;
    !sda_oe_n [*3];
  endsequence
  property p_open_drain;
    sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  property p_busy_quiet;
    write_busy |-> sda_oe_n;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("acked while busy");
  property p_busy_len;
    $fell(write_busy) |-> busy_cnt_reg == WRITE_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length");
  property p_busy_stop;
    $rose(write_busy) |-> s_bus_idle;
  endproperty
  a_busy_stop: assert property (p_busy_stop) else $error("write without stop");
  property p_wp_block;
    $rose(write_busy) |-> wp_cnt_reg < 8'h96;
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("protected write ran");
  property p_drive_low;
    $changed(sda_oe_n) |-> !scl_in;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("data moved, clock high");
  property p_ack_hold;
    $rose(scl_in) && !sda_oe_n |-> s_ack_held;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("low bit not held");
  property p_reset_idle;
    $fell(rst) |-> (sda_oe_n && !write_busy) [*3];
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
endmodule
bind eepw_top eepw_checker #(.WRITE_CYCLES(WRITE_CYCLES)) eepw_checker_inst (
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .write_protect(write_protect), .write_busy(write_busy));
`default_nettype wire

// ===== verification/eepw_bfm.sv
// Bus master model: bus clock of 16 core cycles, high between frames
`timescale 1ns/10ps
`default_nettype none
module eepw_bfm (
  // Pacing clock
  input wire logic clk,
  // Bus lines, data open drain
  output logic scl,
  output logic sda_m,
  input wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data moves mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    w(4);
    scl = 1'b1;
    w(4);
    r = sda_line;
    w(4);
    scl = 1'b0;
    w(4);
  endtask
  // Edge on data while clock high: s=0 start, s=1 stop
  task automatic cond(input logic s);
    sda_m = ~s;
    w(4);
    scl = 1'b1;
    w(8);
    sda_m = s;
    w(8);
    if (!s) scl = 1'b0;
    w(4);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_i2c_eeprom_page_write_read.sv
// Self-checking bench for the serial EEPROM slave access logic
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_eeprom_page_write_read;
  localparam integer WC = 400;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp = 1'b0;
  logic [2:0] straps = 3'h5;
  logic scl, sda_m, sda_out, sda_oe_n, busy;
  logic [7:0] mem [0:4095];
  logic [11:0] cur;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int nk = 0;
  wire logic sda_line = sda_m & (sda_oe_n | sda_out);
  eepw_top #(.WRITE_CYCLES(WC)) eepw_top_inst (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .chip_select_strap_0(straps[0]), .chip_select_strap_1(straps[1]),
    .chip_select_strap_2(straps[2]), .write_protect(wp), .write_busy(busy));
  eepw_bfm eepw_bfm_inst (.clk(clk), .scl(scl), .sda_m(sda_m), .sda_line(sda_line));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Repeats the write header while refused, then sends both address bytes
  task automatic open_w(input logic [11:0] a, output int nacks);
    logic ack;
    nacks = 0;
    ack = 1'b0;
    while (!ack && nacks < 50) begin
      eepw_bfm_inst.cond(1'b0);
      eepw_bfm_inst.send({4'hA, straps, 1'b0}, ack);
      if (!ack) nacks++;
    end
    eepw_bfm_inst.send({4'hF, a[11:8]}, ack);
    chk(ack, 1'b1);
    eepw_bfm_inst.send(a[7:0], ack);
    chk(ack, 1'b1);
  endtask
  task automatic rd(input int n);
    logic ack;
    logic [7:0] d;
    eepw_bfm_inst.cond(1'b0);
    eepw_bfm_inst.send({4'hA, straps, 1'b1}, ack);
    chk(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      eepw_bfm_inst.recv(i == n - 1, d);
      chk(d, mem[cur]);
      cur++;
    end
    eepw_bfm_inst.cond(1'b1);
  endtask
  // Page load, then polled selective read of rn bytes from ra
  task automatic pg_write(input logic [11:0] a, input int n, input logic prot,
                          input logic [11:0] ra, input int rn);
    logic ack;
    int k;
    wp = prot;
    open_w(a, k);
    for (int i = 0; i < (prot ? 1 : n); i++) begin
      eepw_bfm_inst.send(8'h40 + i[7:0], ack);
      chk(ack, !prot);
      if (!prot) mem[{a[11:5], a[4:0] + i[4:0]}] = 8'h40 + i[7:0];
    end
    eepw_bfm_inst.cond(1'b1);
    eepw_bfm_inst.w(10);
    chk(busy, !prot);
    wp = 1'b0;
    open_w(ra, k);
    chk(k > 0, !prot);
    cur = ra;
    rd(rn);
  endtask
  task automatic t_foreign();
    logic ack;
    for (int j = 0; j < 2; j++) begin
      eepw_bfm_inst.cond(1'b0);
      eepw_bfm_inst.send(j ? {4'hB, straps, 1'b1} : {4'hA, straps ^ 3'h2, 1'b1}, ack);
      chk(ack, 1'b0);
      eepw_bfm_inst.cond(1'b1);
    end
    // Other strap levels must move the matching address with them
    straps = 3'h2;
    eepw_bfm_inst.w(4);
    rd(1);
  endtask
  // Protect raised after its strobe edge does not block the request
  task automatic t_wp_late();
    logic ack;
    int k;
    open_w(12'h100, k);
    wp = 1'b1;
    eepw_bfm_inst.send(8'h5A, ack);
    chk(ack, 1'b1);
    mem[12'h100] = 8'h5A;
    wp = 1'b0;
    eepw_bfm_inst.cond(1'b1);
    eepw_bfm_inst.w(10);
    chk(busy, 1'b1);
    open_w(12'h100, k);
    cur = 12'h100;
    rd(1);
  endtask
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    eepw_bfm_inst.w(5);
    open_w(12'hFFE, nk);
    chk(nk[7:0], 8'h00);
    cur = 12'hFFE;
    rd(3);
    pg_write(12'h03E, 34, 1'b0, 12'h01F, 35);
    rd(2);
    pg_write(12'h000, 2, 1'b1, 12'h000, 2);
    pg_write(12'h000, 1, 1'b0, 12'hFFF, 2);
    t_wp_late();
    t_foreign();
    complete_run();
  end
endmodule
`default_nettype wire
